// [hdl/pss_defines.vh]
// Register map, field positions and reset values of the paper sensor block
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PSS_ADDR_SETTINGS   12'h058
`define PSS_ADDR_STATUS     12'h05c
`define PSS_ADDR_CMD        12'h060
`define PSS_ADDR_TRIP_LINES 12'h064
`define PSS_ADDR_INT_STAT   12'h068
`define PSS_ADDR_INT_EN     12'h06c
`define PSS_ADDR_INT_CLR    12'h070

// ****************************************************************
// Settings fields
// ****************************************************************
`define PSS_S1_POL      0
`define PSS_S1_EDGE     1
`define PSS_S1_STOP     2
`define PSS_S2_POL      3
`define PSS_S2_EDGE     4
`define PSS_S2_STOP     5
`define PSS_SET_W       8
`define PSS_SET_RST     8'h00

// ****************************************************************
// Status, command and interrupt fields
// ****************************************************************
`define PSS_ST_S1       0
`define PSS_ST_S2       1
`define PSS_CMD_SCAN    0
`define PSS_IRQ_S1      0
`define PSS_IRQ_S2      1
`define PSS_IRQ_STOP    2
`define PSS_IRQ_W       3
`define PSS_TRIP_W      8
`define PSS_TRIP_RST    8'h00

// ****************************************************************
// Synchroniser warm-up after reset
// ****************************************************************
`define PSS_PRIME_W     3
`define PSS_PRIME_CNT   3'h4
`define PSS_PRIME_ONE   3'h1

`endif

// [hdl/pss_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pss_sync (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_b,
  // Pin side
  input  wire pin_in,
  // Clean level
  output reg  level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // First stage feeds only the second; change counts when 2 and 3 agree
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule // pss_sync

// [hdl/pss_top.v]
// Paper sensor input conditioning with APB register slave
// Function
// R01: Sensor 1 is true when low if polarity bit 0, high if 1.
// R02: Level mode: sensor 1 state bit equals its current true value.
// R03: Edge mode: sensor 1 state bit latches once sensor seen true.
// R04: Edge mode: reading status clears the latched state bit.
// R05: Sensor 1 stop control 0: scanning bit untouched by sensor 1.
// R06: Sensor 1 stop control 1: rising true clears command, halts scan.
// R07: Sensor 2 is true when low if polarity bit 0, high if 1.
// R08: Level mode: sensor 2 state bit equals its current true value.
// R09: Edge mode: sensor 2 state bit latches true since last read.
// R10: Sensor 2 stop control 0: scanning bit untouched by sensor 2.
// R11: Sensor 2 stop 1: rising true stops scan after programmed lines.
// R12: Each sensor input is synchronised before polarity and edge logic.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "pss_defines.vh"
module pss_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst_b,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output reg  [31:0]       prdata,
  output wire              pslverr,
  // Sensor pins and scanner side
  input  wire              paper_sense1,
  input  wire              paper_sense2,
  input  wire              line_done,
  output wire              scanning,
  output wire              irq
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  wire lvl1;
  wire lvl2;

  pss_sync u_sync1 ( // R12
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (paper_sense1),
    .level_q (lvl1)
  );

  pss_sync u_sync2 ( // R12
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (paper_sense2),
    .level_q (lvl2)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [`PSS_SET_W-1:0]  settings_q;
  reg  [`PSS_TRIP_W-1:0] trip_lines_q;
  reg  [`PSS_IRQ_W-1:0]  int_stat_q;
  reg  [`PSS_IRQ_W-1:0]  int_en_q;
  reg                    scan_q;
  reg                    latch1_q;
  reg                    latch2_q;
  reg                    true1_q;
  reg                    true2_q;
  reg                    trip_pend_q;
  reg  [`PSS_TRIP_W-1:0] trip_cnt_q;
  reg  [`PSS_PRIME_W-1:0] prime_q;
  reg                    latch1_d;
  reg                    latch2_d;
  reg  [`PSS_IRQ_W-1:0]  int_stat_d;
  reg  [31:0]            rd_word_d;

  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  // Read word is taken in the setup cycle so it stands through the access
  wire rd_setup = psel & ~penable & ~pwrite;

  function sel;
    input [ADDR_W-1:0] a;
    input [11:0]       r;
    begin
      sel = (a == r[ADDR_W-1:0]);
    end
  endfunction

  // Every listed register answers; anything else is refused
  function known;
    input [ADDR_W-1:0] a;
    begin
      if (sel(a, `PSS_ADDR_SETTINGS)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_STATUS)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_CMD)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_TRIP_LINES)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_INT_STAT)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_INT_EN)) begin
        known = 1'b1;
      end else if (sel(a, `PSS_ADDR_INT_CLR)) begin
        known = 1'b1;
      end else begin
        known = 1'b0;
      end
    end
  endfunction

  wire mapped = known(paddr);

  // Single access cycle; unmapped addresses answer with pslverr
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  wire rd_status = rd & sel(paddr, `PSS_ADDR_STATUS);
  wire wr_settings = wr & sel(paddr, `PSS_ADDR_SETTINGS);
  wire wr_cmd      = wr & sel(paddr, `PSS_ADDR_CMD);
  wire wr_trip     = wr & sel(paddr, `PSS_ADDR_TRIP_LINES);
  wire wr_int_en   = wr & sel(paddr, `PSS_ADDR_INT_EN);
  wire wr_int_clr  = wr & sel(paddr, `PSS_ADDR_INT_CLR);

  function sense_true;
    input pol;
    input lvl;
    begin
      sense_true = pol ? lvl : ~lvl;
    end
  endfunction

  // ****************************************************************
  // Synchroniser warm-up
  // ****************************************************************
  // Synchronisers leave reset at 0, which reads as true under low-true
  // polarity; edges and latches wait until real pin levels have arrived
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      prime_q <= {`PSS_PRIME_W{1'b0}};
    end else if (prime_q != `PSS_PRIME_CNT) begin
      prime_q <= prime_q + `PSS_PRIME_ONE;
    end
  end

  wire primed = (prime_q == `PSS_PRIME_CNT); // R12

  // ****************************************************************
  // Polarity and edge detect
  // ****************************************************************
  wire true1 = primed & sense_true(settings_q[`PSS_S1_POL], lvl1); // R01
  wire true2 = primed & sense_true(settings_q[`PSS_S2_POL], lvl2); // R07
  wire rise1 = true1 & ~true1_q;
  wire rise2 = true2 & ~true2_q;

  wire edge1 = settings_q[`PSS_S1_EDGE];
  wire edge2 = settings_q[`PSS_S2_EDGE];
  // A true sensor shows at once, so a read cannot miss a set in flight
  wire st1   = edge1 ? (latch1_q | true1) : true1; // R02
  wire st2   = edge2 ? (latch2_q | true2) : true2; // R08

  wire stop1 = rise1 & settings_q[`PSS_S1_STOP]; // R05 R06
  wire stop2_done = trip_pend_q & line_done &
                    (trip_cnt_q == {`PSS_TRIP_W{1'b0}});
  wire stop2_now  = rise2 & settings_q[`PSS_S2_STOP] &
                    (trip_lines_q == {`PSS_TRIP_W{1'b0}});
  wire stop_evt   = scan_q & (stop1 | stop2_now | stop2_done);

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      true1_q <= 1'b0;
      true2_q <= 1'b0;
      latch1_q <= 1'b0;
      latch2_q <= 1'b0;
    end else begin
      true1_q <= true1;
      true2_q <= true2;
      latch1_q <= latch1_d;
      latch2_q <= latch2_d;
    end
  end

  // A true sensor in the read cycle stays latched: set beats clear
  always @* begin
    latch1_d = latch1_q;
    latch2_d = latch2_q;
    if (true1) begin
      latch1_d = 1'b1; // R03
    end else if (rd_status) begin
      latch1_d = 1'b0; // R04
    end
    if (true2) begin
      latch2_d = 1'b1; // R09
    end else if (rd_status) begin
      latch2_d = 1'b0; // R04
    end
  end

  // ****************************************************************
  // Scan command and trip countdown
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      scan_q      <= 1'b0;
      trip_pend_q <= 1'b0;
      trip_cnt_q  <= `PSS_TRIP_RST;
    end else begin
      if (stop_evt) begin
        scan_q      <= 1'b0; // R06 R11
        trip_pend_q <= 1'b0;
      end else if (wr_cmd) begin
        scan_q      <= pwdata[`PSS_CMD_SCAN];
        trip_pend_q <= 1'b0;
      end else if (rise2 & settings_q[`PSS_S2_STOP] & scan_q &
                   ~trip_pend_q) begin
        // Count starts at the trip; each finished line counts down
        trip_pend_q <= 1'b1; // R10 R11
        trip_cnt_q  <= trip_lines_q - 8'h01;
      end else if (trip_pend_q & line_done) begin
        trip_cnt_q  <= trip_cnt_q - 8'h01; // R11
      end
    end
  end

  assign scanning = scan_q;

  // ****************************************************************
  // Settings and interrupt registers
  // ****************************************************************
  wire [`PSS_IRQ_W-1:0] evt = {stop_evt, rise2, rise1};

  // New events win over a write-one clear in the same cycle
  always @* begin
    int_stat_d = int_stat_q | evt;
    if (wr_int_clr) begin
      int_stat_d = (int_stat_q & ~pwdata[`PSS_IRQ_W-1:0]) | evt;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      settings_q   <= `PSS_SET_RST;
      trip_lines_q <= `PSS_TRIP_RST;
      int_en_q     <= {`PSS_IRQ_W{1'b0}};
      int_stat_q   <= {`PSS_IRQ_W{1'b0}};
    end else begin
      if (wr_settings) begin
        settings_q <= pwdata[`PSS_SET_W-1:0];
      end
      if (wr_trip) begin
        trip_lines_q <= pwdata[`PSS_TRIP_W-1:0];
      end
      if (wr_int_en) begin
        int_en_q <= pwdata[`PSS_IRQ_W-1:0];
      end
      int_stat_q <= int_stat_d;
    end
  end

  assign irq = |(int_stat_q & int_en_q);

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped and write-only addresses read as zero
  always @* begin
    rd_word_d = 32'h0000_0000;
    if (sel(paddr, `PSS_ADDR_SETTINGS)) begin
      rd_word_d = {24'h0, settings_q};
    end else if (sel(paddr, `PSS_ADDR_STATUS)) begin
      rd_word_d = {30'h0, st2, st1};
    end else if (sel(paddr, `PSS_ADDR_CMD)) begin
      rd_word_d = {31'h0, scan_q};
    end else if (sel(paddr, `PSS_ADDR_TRIP_LINES)) begin
      rd_word_d = {24'h0, trip_lines_q};
    end else if (sel(paddr, `PSS_ADDR_INT_STAT)) begin
      rd_word_d = {29'h0, int_stat_q};
    end else if (sel(paddr, `PSS_ADDR_INT_EN)) begin
      rd_word_d = {29'h0, int_en_q};
    end
  end

  // Loaded at the setup edge so the word stands while pready is high
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_word_d;
    end
  end

endmodule // pss_top

// [sim/pss_switch.sv]
// Model of the two paper presence switches
`timescale 1ns/1ns
module pss_switch #(
  parameter DLY = 3
) (
  // Wanted levels
  input  wire [1:0] want,
  // Sensor pins
  output wire       paper_sense1,
  output wire       paper_sense2
);
  // Off the clock edge, as a real contact is
  assign #DLY paper_sense1 = want[0];
  assign #DLY paper_sense2 = want[1];
endmodule // pss_switch

// [sim/pss_top_asserts.sv]
// Port checker for the paper sensor block
`timescale 1ns/1ns
module pss_chk #(
  parameter ADDR_W = 12
) (
  // Clock, reset, bus
  input wire              sys_clk,
  input wire              rst_b,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire              pready,
  input wire [31:0]       prdata,
  input wire              pslverr,
  // Pins
  input wire              paper_sense1,
  input wire              paper_sense2,
  input wire              line_done,
  input wire              scanning,
  input wire              irq
);
  reg  [7:0] set_q;
  reg  [3:0] stab_q;
  reg  [1:0] pin_q;
  wire       acc = psel & penable;
  wire       rd  = acc & !pwrite & paddr == 12'h05c;
  wire       t1  = set_q[0] ~^ paper_sense1;
  wire       t2  = set_q[3] ~^ paper_sense2;
  // Pins must sit still well past the synchroniser delay
  always @(posedge sys_clk) begin
    pin_q <= {paper_sense2, paper_sense1};
    if (!rst_b)
      set_q <= 8'h00;
    else if (acc & pwrite & paddr == 12'h058)
      set_q <= pwdata[7:0];
    if (!rst_b || pin_q != {paper_sense2, paper_sense1})
      stab_q <= 4'h0;
    else if (stab_q != 4'hf)
      stab_q <= stab_q + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence quiet1;
    rd & stab_q > 4'h9 & set_q[1] & !t1;
  endsequence
  chk_err_idle:
    assert property (!acc |-> !pslverr) else $error("stray pslverr");
  chk_ok_map:
    assert property (acc & paddr == 12'h058 |-> !pslverr)
      else $error("pslverr on map");
  chk_scan_set:
    assert property ($rose(scanning) |->
      $past(acc & pwrite & paddr == 12'h060 & pwdata[0]))
      else $error("scan set without write");
  chk_scan_hold:
    assert property (scanning & !set_q[2] & !set_q[5] & !(acc & pwrite)
      |=> scanning) else $error("scan dropped");
  chk_lvl_one:
    assert property (rd & stab_q > 4'h9 & !set_q[1]
      |-> prdata[0] == t1) else $error("sensor 1 level");
  chk_lvl_two:
    assert property (rd & stab_q > 4'h9 & !set_q[4]
      |-> prdata[1] == t2) else $error("sensor 2 level");
  chk_seen_true:
    assert property (rd & stab_q > 4'h9 & t1 |-> prdata[0])
      else $error("sensor 1 not seen");
  chk_rd_clear:
    assert property (quiet1 ##[2:8] quiet1 |-> !prdata[0])
      else $error("latch not cleared");
  cover property (rd);
  cover property ($fell(scanning));
  cover property (irq);
endmodule // pss_chk

bind pss_top pss_chk #(.ADDR_W(ADDR_W)) pss_chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .paper_sense1(paper_sense1),
  .paper_sense2(paper_sense2), .line_done(line_done),
  .scanning(scanning), .irq(irq));

// [sim/paper_sensor_input_conditioning_tb.sv]
// Self-checking bench for the paper sensor block
`timescale 1ns/1ns
`include "pss_defines.vh"
module paper_sensor_input_conditioning_tb;
  reg         sys_clk, rst_b, psel, penable, pwrite, line_done, err_v;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd_v;
  reg  [1:0]  want;
  reg  [11:0] rows [0:3];
  wire        pready, pslverr, ps1, ps2, scanning, irq;
  wire [31:0] prdata;
  integer     n_fail, n_compared, i;
  pss_top pss_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .paper_sense1(ps1), .paper_sense2(ps2), .line_done(line_done),
    .scanning(scanning), .irq(irq));
  pss_switch pss_switch_i (.want(want), .paper_sense1(ps1),
    .paper_sense2(ps2));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Read data stands in the access cycle; a spare edge lets outputs settle
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 16) begin
        chk(0, 1);
        results;
      end
      err_v = pslverr;
      rd_v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task pulse(input [1:0] p);
    begin
      want <= p;
      repeat (8) @(posedge sys_clk);
      want <= 2'b11;
      repeat (12) @(posedge sys_clk);
    end
  endtask
  task ld;
    begin
      @(posedge sys_clk);
      line_done <= 1'b1;
      @(posedge sys_clk);
      line_done <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, psel, penable, pwrite, line_done} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 2'b11;
    n_fail = 0;
    n_compared = 0;
    rows[0] = {8'h00, 2'b00, 2'b11};
    rows[1] = {8'h00, 2'b11, 2'b00};
    rows[2] = {8'h09, 2'b11, 2'b11};
    rows[3] = {8'h09, 2'b01, 2'b01};
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(0, `PSS_ADDR_SETTINGS, 0);
    chk(rd_v, `PSS_SET_RST);
    chk({scanning, irq}, 0);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, `PSS_ADDR_SETTINGS, rows[i][11:4]);
      want <= rows[i][3:2];
      repeat (12) @(posedge sys_clk);
      apb(0, `PSS_ADDR_SETTINGS, 0);
      chk(rd_v, rows[i][11:4]);
      apb(0, `PSS_ADDR_STATUS, 0);
      chk(rd_v, rows[i][1:0]);
    end
    apb(0, 12'h0f0, 0);
    chk({err_v, rd_v[30:0]}, 32'h80000000);
    apb(1, `PSS_ADDR_SETTINGS, 8'h12);
    pulse(2'b11);
    apb(0, `PSS_ADDR_STATUS, 0);
    apb(1, `PSS_ADDR_INT_CLR, 7);
    pulse(2'b00);
    apb(0, `PSS_ADDR_STATUS, 0);
    chk(rd_v, 3);
    apb(0, `PSS_ADDR_STATUS, 0);
    chk(rd_v, 0);
    apb(1, `PSS_ADDR_INT_EN, 3);
    chk(irq, 1);
    apb(1, `PSS_ADDR_INT_EN, 0);
    chk(irq, 0);
    apb(1, `PSS_ADDR_SETTINGS, 8'h00);
    apb(1, `PSS_ADDR_CMD, 1);
    pulse(2'b00);
    chk(scanning, 1);
    apb(1, `PSS_ADDR_SETTINGS, 8'h04);
    pulse(2'b10);
    chk(scanning, 0);
    apb(1, `PSS_ADDR_INT_EN, 4);
    chk(irq, 1);
    apb(1, `PSS_ADDR_INT_CLR, 7);
    chk(irq, 0);
    apb(1, `PSS_ADDR_SETTINGS, 8'h20);
    apb(1, `PSS_ADDR_TRIP_LINES, 2);
    apb(1, `PSS_ADDR_CMD, 1);
    pulse(2'b01);
    ld;
    chk(scanning, 1);
    ld;
    chk(scanning, 0);
    apb(1, `PSS_ADDR_CMD, 1);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk(scanning, 0);
    repeat (8) @(posedge sys_clk);
    apb(0, `PSS_ADDR_SETTINGS, 0);
    chk(rd_v, `PSS_SET_RST);
    apb(0, `PSS_ADDR_INT_STAT, 0);
    chk(rd_v, 0);
    results;
  end
endmodule // paper_sensor_input_conditioning_tb
